//--- pkg/sfpg_pkg.sv
// package: timing constants, pin positions and power states of the power-up gate
package sfpg_pkg;
	// system clock rate
	localparam int unsigned CLK_MHZ = 250;
	// longest internal delay before program or erase, in ms
	localparam int unsigned PUW_MS = 3;
	// longest time converted to whole cycles
	localparam int unsigned PUW_CYCLES_DFLT = (PUW_MS * 1000 * CLK_MHZ);
	// host-side least wait from supply good to select low, in us (kept by host)
	localparam int unsigned VCSL_US = 70;
	// synchroniser lane positions
	localparam int unsigned PIN_POR = 0;
	localparam int unsigned PIN_CS = 1;
	localparam int unsigned PIN_SCK = 2;
	localparam int unsigned PIN_W = 3;
	// idle levels: por active, select high, clock low
	localparam logic [2:0] PIN_RST = 3'h3;
	// power state of the device
	typedef enum logic [1:0]
	{
		st_por,
		st_wait,
		st_standby,
		st_active
	} sfpg_state_t;
endpackage

//--- pkg/sfpg_if.sv
// interface: raw pins into the synchroniser and the filtered levels back out
interface sfpg_if;
	import sfpg_pkg::*;
	// raw asynchronous pin levels
	logic [PIN_W-1:0] raw;
	// filtered levels in the system clock domain
	logic [PIN_W-1:0] clean;
	modport sync (input raw, output clean);
	modport user (output raw, input clean);
endinterface

//--- rtl/sfpg_sync.sv
// module: three-stage pin synchroniser with agreement filter
module sfpg_sync
	import sfpg_pkg::*;
#(
	parameter int unsigned W = PIN_W,
	parameter logic [W-1:0] RST = PIN_RST
)
(
	input wire logic clk_sys,
	input wire logic reset_n,
	sfpg_if.sync pins
);
	// three stages per lane
	logic [W-1:0] ff1_r;
	logic [W-1:0] ff2_r;
	logic [W-1:0] ff3_r;
	logic [W-1:0] clean_r;
	logic [W-1:0] clean_nxt;

	// a lane only changes once stages two and three agree
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_lane
			always_comb
			begin
				clean_nxt[i] = (ff2_r[i] == ff3_r[i]) ? ff3_r[i] : clean_r[i];
			end
		end
	endgenerate

	// stage one feeds only stage two, so metastability never reaches logic
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ff1_r <= RST;
			ff2_r <= RST;
			ff3_r <= RST;
			clean_r <= RST;
		end
		else
		begin
			ff1_r <= pins.raw;
			ff2_r <= ff1_r;
			ff3_r <= ff2_r;
			clean_r <= clean_nxt;
		end
	end

	assign pins.clean = clean_r;
endmodule

//--- rtl/sfpg_gate.sv
// module: power-on and reset entry gate of the serial flash interface
// How it works
// - output stays high impedance until commanded
// - instructions need a select falling edge first
// - sample clock idle level at select fall
// - power-on reset ignores all commands
// - program or erase blocked until delay ends
// - after delay: standby if deselected, else active
module sfpg_gate
	import sfpg_pkg::*;
#(
	parameter int unsigned PUW_CYCLES = PUW_CYCLES_DFLT,
	parameter int unsigned CNT_W = $clog2(PUW_CYCLES + 1)
)
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic por_active,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic so_drive,
	input wire logic so_data,
	input wire logic pe_req,
	output logic so_out,
	output logic so_oe,
	output logic cmd_start,
	output logic frame_open,
	output logic clk_mode3,
	output logic pe_grant,
	output logic pe_ready,
	output sfpg_pkg::sfpg_state_t pwr_state
);
	import sfpg_pkg::*;

	// pins cross into the clock domain through the filter
	sfpg_if pins ();
	logic por_s;
	logic cs_s;
	logic sck_s;

	assign pins.raw[PIN_POR] = por_active;
	assign pins.raw[PIN_CS] = cs_n;
	assign pins.raw[PIN_SCK] = sck;

	sfpg_sync #(.W(PIN_W), .RST(PIN_RST)) u_sync
	(
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.pins(pins)
	);

	assign por_s = pins.clean[PIN_POR];
	assign cs_s = pins.clean[PIN_CS];
	assign sck_s = pins.clean[PIN_SCK];

	// state and its next values
	sfpg_state_t st_r;
	sfpg_state_t st_nxt;
	logic [CNT_W-1:0] cnt_r; // power-up delay counter
	logic [CNT_W-1:0] cnt_nxt;
	logic cs_prev_r; // select level one cycle back
	logic cs_prev_nxt; // forced low under power-on reset so a held-low select never looks like a fall
	logic open_r; // a valid frame is in progress
	logic open_nxt;
	logic mode_r; // 1 = clock mode 3, 0 = mode 0
	logic mode_nxt;
	logic start_r; // one-cycle instruction start
	logic start_nxt;
	logic so_oe_r;
	logic so_oe_nxt;
	logic so_out_r;
	logic so_out_nxt;
	logic cs_fall;
	logic delay_done;

	// select high-to-low seen on the filtered level
	assign cs_fall = cs_prev_r & ~cs_s;
	assign delay_done = (cnt_r == CNT_W'(PUW_CYCLES - 1));

	// next-state logic for power state, frame and output driver
	always_comb
	begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		open_nxt = open_r;
		mode_nxt = mode_r;
		start_nxt = 1'b0;
		so_oe_nxt = 1'b0;
		so_out_nxt = so_data;
		cs_prev_nxt = cs_s;
		if (por_s)
		begin
			st_nxt = st_por;
			cnt_nxt = '0;
			open_nxt = 1'b0;
			// disarm edge detector until select is seen high
			cs_prev_nxt = 1'b0;
		end
		else
		begin
			case (st_r)
				st_por:
				begin
					// delay starts once the supply is valid
					st_nxt = st_wait;
					cnt_nxt = '0;
				end
				st_wait:
				begin
					if (delay_done)
						st_nxt = cs_s ? st_standby : st_active;
					else
						cnt_nxt = cnt_r + CNT_W'(1);
				end
				default:
				begin
					// track select level once settled
					st_nxt = cs_s ? st_standby : st_active;
				end
			endcase
			if (cs_fall)
			begin
				open_nxt = 1'b1;
				start_nxt = 1'b1;
				mode_nxt = sck_s;
			end
			else if (cs_s)
			begin
				open_nxt = 1'b0;
			end
			so_oe_nxt = open_r & ~cs_s & so_drive;
		end
	end

	// registers only; a select held low through reset release never opens a frame
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_r <= st_por;
			cnt_r <= '0;
			cs_prev_r <= 1'b1;
			open_r <= 1'b0;
			mode_r <= 1'b0;
			start_r <= 1'b0;
			so_oe_r <= 1'b0;
			so_out_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			cs_prev_r <= cs_prev_nxt;
			open_r <= open_nxt;
			mode_r <= mode_nxt;
			start_r <= start_nxt;
			so_oe_r <= so_oe_nxt;
			so_out_r <= so_out_nxt;
		end
	end

	assign pe_ready = (st_r == st_standby) || (st_r == st_active);
	assign pe_grant = pe_req & open_r & pe_ready & ~por_s;

	assign so_out = so_out_r;
	assign so_oe = so_oe_r;
	assign cmd_start = start_r;
	assign frame_open = open_r;
	assign clk_mode3 = mode_r;
	assign pwr_state = st_r;

	// helper: cycles since supply valid, saturating, read only by checks
	logic [CNT_W-1:0] since_r;
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			since_r <= '0;
		else if (por_s)
			since_r <= '0;
		else if (since_r != CNT_W'(PUW_CYCLES))
			since_r <= since_r + CNT_W'(1);
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	a_so_hiz_por: assert property (por_s |=> !so_oe)
		else $error("serial output driven under power-on reset");
	a_start_after_fall: assert property (cmd_start |-> $past(cs_fall) && !$past(por_s))
		else $error("instruction started without a select fall");
	a_frame_closes: assert property (cs_s && !por_s |=> !frame_open)
		else $error("frame stayed open with select high");
	a_mode_sampled: assert property (cmd_start |-> clk_mode3 == $past(sck_s))
		else $error("clock mode not taken from idle clock level");
	a_por_ignored: assert property (por_s |=> !cmd_start && !frame_open && pwr_state == st_por)
		else $error("command taken under power-on reset");
	a_pe_delay: assert property (pe_grant |-> since_r >= CNT_W'(PUW_CYCLES))
		else $error("program or erase granted before delay");
	a_delay_exit: assert property (st_r == st_wait && delay_done && !por_s |=>
		pwr_state == ($past(cs_s) ? st_standby : st_active))
		else $error("wrong state after power-up delay");
	// output enable only follows a driven, still-selected frame
	a_oe_in_frame: assert property (so_oe |-> $past(open_r) && !$past(cs_s) && $past(so_drive))
		else $error("serial output driven outside a frame");
	// a frame only opens together with an instruction start
	a_open_on_start: assert property ($rose(frame_open) |-> cmd_start)
		else $error("frame opened without instruction start");

	c_mode3_frame: cover property (cmd_start && clk_mode3);
	c_mode0_frame: cover property (cmd_start && !clk_mode3);
	c_pe_granted: cover property (pe_grant);
	c_so_driven: cover property (so_oe);
	c_active_exit: cover property (st_r == st_wait ##1 st_r == st_active);
endmodule

//--- dv/sfpg_host.sv
// host model: drives power-on reset, select and clock idle level
module sfpg_host
	import sfpg_pkg::*;
#(
	parameter int unsigned SEL_WAIT = VCSL_US * CLK_MHZ
)
(
	input wire logic clk_sys,
	output logic por_active,
	output logic cs_n,
	output logic sck
);
	timeunit 1ns;
	timeprecision 1ps;
	// por active, deselected, clock idle low
	initial
	begin
		por_active = 1'h1;
		cs_n = 1'h1;
		sck = 1'h0;
	end
	// idle level settles before select falls
	task automatic open_frame(input logic lvl);
		sck <= lvl;
		repeat (4) @(posedge clk_sys);
		cs_n <= 1'h0;
	endtask
	// count cycles from supply good before any select
	task automatic power_good();
		por_active <= 1'h0;
		repeat (SEL_WAIT) @(posedge clk_sys);
	endtask
	// select back high ends the frame
	task automatic close_frame();
		cs_n <= 1'h1;
		repeat (8) @(posedge clk_sys);
	endtask
endmodule

//--- dv/sfpg_gate_tb.sv
// testbench: power-up gate against the host model
module sfpg_gate_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sfpg_pkg::*;
	// short delay so the run stays brief
	localparam int unsigned PUW = 20;
	logic clk_sys, reset_n, so_drive, so_data, pe_req;
	logic por_active, cs_n, sck, so_out, so_oe, cmd_start, frame_open, clk_mode3, pe_grant, pe_ready;
	sfpg_state_t pwr_state;
	int n_fail = 0;
	int tests_run = 0;
	// host wait shortened like the delay
	sfpg_host #(.SEL_WAIT(4)) host (.clk_sys(clk_sys), .por_active(por_active), .cs_n(cs_n), .sck(sck));
	sfpg_gate #(.PUW_CYCLES(PUW)) DUT (.clk_sys(clk_sys), .reset_n(reset_n), .por_active(por_active),
		.cs_n(cs_n), .sck(sck), .so_drive(so_drive), .so_data(so_data), .pe_req(pe_req), .so_out(so_out),
		.so_oe(so_oe), .cmd_start(cmd_start), .frame_open(frame_open), .clk_mode3(clk_mode3),
		.pe_grant(pe_grant), .pe_ready(pe_ready), .pwr_state(pwr_state));
	// free-running 250 MHz clock
	initial
	begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end
	// compare a single output bit
	task automatic chk(input logic got, input logic exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t bit mismatch", $time);
		end
	endtask
	// compare the power state
	task automatic chk_st(input sfpg_state_t exp);
		tests_run++;
		if (pwr_state !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t state mismatch", $time);
		end
	endtask
	task automatic close_out();
		$display("fails %0d of %0d checks", n_fail, tests_run);
		if (n_fail == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// frames under power-on reset must be ignored
	task automatic s_por();
		so_drive <= 1'h1;
		host.open_frame(1'h1);
		repeat (10)
		begin
			@(negedge clk_sys);
			chk(cmd_start, 1'h0);
			chk(so_oe, 1'h0);
		end
		chk_st(st_por);
		@(posedge clk_sys);
		so_drive <= 1'h0;
		host.close_frame();
	endtask
	// one frame: mode pick, output drive, program grant
	task automatic s_frame(input logic lvl, input logic gr, input sfpg_state_t st);
		int k;
		host.open_frame(lvl);
		k = 0;
		while (cmd_start !== 1'h1 && k < 8)
		begin
			@(negedge clk_sys);
			k++;
		end
		chk(cmd_start, 1'h1);
		chk(clk_mode3, lvl);
		@(posedge clk_sys);
		so_drive <= 1'h1;
		so_data <= ~lvl;
		pe_req <= 1'h1;
		@(negedge clk_sys);
		chk(cmd_start, 1'h0);
		chk(pe_grant, gr);
		@(negedge clk_sys);
		chk(so_oe, 1'h1);
		chk(so_out, ~lvl);
		chk_st(st);
		@(posedge clk_sys);
		so_drive <= 1'h0;
		pe_req <= 1'h0;
		host.close_frame();
		@(negedge clk_sys);
		chk(so_oe, 1'h0);
		chk(frame_open, 1'h0);
	endtask
	// delay expiry lands in the given state: standby with select high, active with select low
	task automatic s_delay(input sfpg_state_t st);
		int k;
		k = 0;
		while (pe_ready !== 1'h1 && k < PUW + 10)
		begin
			@(negedge clk_sys);
			k++;
		end
		chk(pe_ready, 1'h1);
		chk_st(st);
		@(posedge clk_sys);
	endtask
	// mid-run reset with select held low: output off, no frame, delay ends active
	task automatic s_reset();
		@(posedge clk_sys);
		host.open_frame(1'h1);
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(frame_open, 1'h1);
		@(posedge clk_sys);
		reset_n <= 1'h0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'h1;
		@(negedge clk_sys);
		chk_st(st_por);
		repeat (12)
		begin
			chk(so_oe, 1'h0);
			chk(frame_open, 1'h0);
			chk(cmd_start, 1'h0);
			@(negedge clk_sys);
		end
		s_delay(st_active);
		host.close_frame();
	endtask
	initial
	begin
		reset_n = 1'h0;
		so_drive = 1'h0;
		so_data = 1'h0;
		pe_req = 1'h0;
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'h1;
		s_por();
		host.power_good();
		s_frame(1'h1, 1'h0, st_wait);
		s_delay(st_standby);
		s_frame(1'h0, 1'h1, st_active);
		s_reset();
		close_out();
	end
	// hang guard, well beyond the expected run
	initial
	begin
		#20000;
		n_fail++;
		close_out();
	end
endmodule
